// *** scr_defines.vh ***
// Constants for the serial control read engine: codes, bytes and bit counts.
// Assumes inclusion by bare name from scr_read_port.v and scr_sync.v.
// Function
// - Attention low while outgoing data waits.
// - Acknowledge valid read address in ninth clock.
// - Data changes on falling, sampled on rising.
// - Two-wire: release at D0 rise if empty.
// - Attention stays high until next rising edge.
// - Solicited mode: assert only after read request.
// - Unsolicited mode: assert whenever message queued.
// - Early unsolicited message keeps attention low.
// - Late message: high one clock, low at N.
// - Four-wire: release at D1, refall at D0.
// - Continued read after pulse gets one filler.
// - Responses never start with zero byte, except a two-wire repeated start after a NACKed pulse.
// - Stop after pulse loads message, no filler.
// - Data line driven low only, released high.
`ifndef SCR_DEFINES_VH
`define SCR_DEFINES_VH
// Address byte that opens a read
`define SCR_ADDR_READ 8'h01
// Filler and idle bytes
`define SCR_FILLER 8'h00
`define SCR_IDLE_BYTE 8'hff
// Rising edge numbers within a byte
`define SCR_NM1_I2C 4'h8
`define SCR_NM1_SPI 4'h7
`define SCR_BYTE_END 4'h8
`define SCR_CNT_RST 4'h0
`define SCR_CNT_ONE 4'h1
// Synchroniser reset image {spi_mode, cs_n, sda, clk}: two-wire, lines idle high
`define SCR_SYNC_RST 4'h7
`define SCR_SYNC_W 4
`endif

// *** scr_sync.v ***
// Two-flop synchroniser for a small group of pin levels.
// Assumes CLK is the block clock; outputs are only read downstream.
`timescale 1ns/1ps
`include "scr_defines.vh"
module scr_sync (
	// Clock, reset, enable
	input wire clk,
	input wire srst,
	input wire ce,
	// Pin levels in, clean levels out
	input wire [`SCR_SYNC_W-1:0] pin_i,
	output reg [`SCR_SYNC_W-1:0] sync_o
);
	reg [`SCR_SYNC_W-1:0] meta_q;

	// First stage feeds only the second stage
	always @(posedge clk) begin
		if (srst) begin
			meta_q <= `SCR_SYNC_RST;
			sync_o <= `SCR_SYNC_RST;
		end else if (ce) begin
			meta_q <= pin_i;
			sync_o <= meta_q;
		end
	end
endmodule // scr_sync

// *** scr_read_port.v ***
// Read side of the serial control port: two-wire and four-wire response
// shifting with host attention handling and filler insertion.
// Assumes the message source holds MSG_VALID/MSG_DATA until MSG_TAKE and keeps
// MSG_VALID high for every remaining byte of a queued message.
`timescale 1ns/1ps
`include "scr_defines.vh"
module scr_read_port (
	// Clock, reset, enable
	input wire CLK,
	input wire SRST,
	input wire CE,
	// Link pins from the host
	input wire SPI_MODE,
	input wire SERIAL_CONTROL_CLOCK,
	input wire SERIAL_CHIP_SELECT_N,
	input wire SERIAL_DATA_IO_I,
	// Link pins to the host
	output reg SERIAL_DATA_IO_O,
	output reg SERIAL_DATA_IO_OE,
	output reg CONTROL_DATA_OUT,
	output reg HOST_ATTENTION_N,
	// Message source
	input wire MSG_VALID,
	input wire [7:0] MSG_DATA,
	output reg MSG_TAKE,
	// Messaging mode and host read requests
	input wire UNSOL_EN,
	input wire READ_REQ
);
	// One-hot states
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_ADDR = 5'h02;
	localparam [4:0] ST_AACK = 5'h04;
	localparam [4:0] ST_TX = 5'h08;
	localparam [4:0] ST_HACK = 5'h10;

	wire [`SCR_SYNC_W-1:0] pins_s;
	wire spi_s;
	wire cs_n_s;
	wire sda_s;
	wire clk_s;
	reg clk_prev_q;
	reg sda_prev_q;
	reg cs_prev_q;
	reg [4:0] state_q;
	reg [4:0] state_d;
	reg [3:0] cnt_q;
	reg [3:0] cnt_d;
	reg [7:0] rx_q;
	reg [7:0] rx_d;
	reg [7:0] tx_q;
	reg [7:0] tx_d;
	reg out_bit_q;
	reg out_bit_d;
	reg drive_q;
	reg drive_d;
	reg hack_q;
	reg hack_d;
	reg have_byte_q;
	reg have_byte_d;
	reg hold_q;
	reg hold_d;
	reg att_q;
	reg att_d;
	reg armed_q;
	reg armed_d;
	reg filler_q;
	reg filler_d;
	reg take_d;
	reg load;
	reg [7:0] load_byte;
	wire rise;
	wire fall;
	wire start_ev;
	wire stop_ev;
	wire frame_on;
	wire frame_off;
	wire pending;
	wire [3:0] nm1;
	wire [3:0] cnt_inc;

	// All link pins cross through two flops before use
	scr_sync u_sync (
		.clk(CLK),
		.srst(SRST),
		.ce(CE),
		.pin_i({SPI_MODE, SERIAL_CHIP_SELECT_N, SERIAL_DATA_IO_I, SERIAL_CONTROL_CLOCK}),
		.sync_o(pins_s)
	);
	assign spi_s = pins_s[3];
	assign cs_n_s = pins_s[2];
	assign sda_s = pins_s[1];
	assign clk_s = pins_s[0];

	// Edges of the host clock and framing events
	assign rise = clk_s & ~clk_prev_q;
	assign fall = ~clk_s & clk_prev_q;
	assign start_ev = ~spi_s & clk_s & clk_prev_q & sda_prev_q & ~sda_s;
	assign stop_ev = ~spi_s & clk_s & clk_prev_q & ~sda_prev_q & sda_s;
	assign frame_on = start_ev | (spi_s & cs_prev_q & ~cs_n_s);
	assign frame_off = stop_ev | (spi_s & ~cs_prev_q & cs_n_s);
	assign cnt_inc = cnt_q + `SCR_CNT_ONE;
	// Release point: D0 rise on two-wire, D1 rise on four-wire
	assign nm1 = spi_s ? `SCR_NM1_SPI : `SCR_NM1_I2C;
	// Messages count only when the host may see them
	assign pending = MSG_VALID & (armed_q | UNSOL_EN);

	// Next byte for the shift register: filler first after a pulse
	always @* begin
		load_byte = `SCR_IDLE_BYTE;
		take_d = 1'b0;
		if (filler_q) begin
			load_byte = `SCR_FILLER;
		end else if (pending) begin
			load_byte = MSG_DATA;
			take_d = load;
		end
	end

	// Link state machine and shifting
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		rx_d = rx_q;
		tx_d = tx_q;
		out_bit_d = out_bit_q;
		drive_d = drive_q;
		hack_d = hack_q;
		load = 1'b0;
		if (frame_off) begin
			state_d = ST_IDLE;
			drive_d = 1'b0;
			out_bit_d = 1'b1;
		end else if (frame_on) begin
			state_d = ST_ADDR;
			cnt_d = `SCR_CNT_RST;
			drive_d = 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					drive_d = 1'b0;
				end
				ST_ADDR: begin
					if (rise) begin
						rx_d = {rx_q[6:0], sda_s};
						cnt_d = cnt_inc;
					end else if (fall && cnt_q == `SCR_BYTE_END) begin
						if (rx_q != `SCR_ADDR_READ) begin
							state_d = ST_IDLE; // Writes and other addresses left unanswered
						end else if (spi_s) begin
							load = 1'b1;
							state_d = ST_TX;
							cnt_d = `SCR_CNT_RST;
						end else begin
							drive_d = 1'b1;
							state_d = ST_AACK;
						end
					end
				end
				ST_AACK: begin
					if (fall) begin
						load = 1'b1;
						state_d = ST_TX;
						cnt_d = `SCR_CNT_RST;
					end
				end
				ST_TX: begin
					if (rise) begin
						cnt_d = cnt_inc;
					end else if (fall) begin
						if (cnt_q != `SCR_BYTE_END) begin
							out_bit_d = tx_q[7];
							tx_d = {tx_q[6:0], 1'b1};
						end else if (spi_s) begin
							load = 1'b1;
							cnt_d = `SCR_CNT_RST;
						end else begin
							drive_d = 1'b0;
							out_bit_d = 1'b1;
							state_d = ST_HACK;
						end
					end
				end
				ST_HACK: begin
					if (rise) begin
						hack_d = ~sda_s;
					end else if (fall) begin
						if (hack_q) begin
							load = 1'b1;
							state_d = ST_TX;
							cnt_d = `SCR_CNT_RST;
						end else begin
							state_d = ST_IDLE; // No acknowledge ends the read
						end
					end
				end
				default: begin
					state_d = ST_IDLE;
					drive_d = 1'b0;
				end
			endcase
		end
		if (load) begin
			out_bit_d = load_byte[7];
			tx_d = {load_byte[6:0], 1'b1};
			drive_d = ~spi_s;
		end
	end

	// Attention, hold-high window, arming and filler tracking
	always @* begin
		have_byte_d = have_byte_q;
		hold_d = hold_q;
		armed_d = armed_q;
		filler_d = filler_q;
		att_d = att_q;
		if (load) begin
			have_byte_d = filler_q | pending;
			filler_d = 1'b0;
		end
		if (frame_off) begin
			filler_d = 1'b0;
		end
		if (rise && hold_q) begin
			hold_d = 1'b0;
			if (pending && state_q == (spi_s ? ST_TX : ST_HACK)) begin
				filler_d = 1'b1;
			end
		end else if (rise && state_q == ST_TX && cnt_inc == nm1) begin
			have_byte_d = 1'b0;
			if (!pending) begin
				hold_d = 1'b1;
			end
		end
		// Low while a byte is owed or a message waits, unless in the high window
		if (hold_d) begin
			att_d = 1'b0;
		end else begin
			att_d = have_byte_d | pending;
		end
		// Solicited mode disarms when the line rises; a new request wins
		if (att_q && !att_d) begin
			armed_d = 1'b0;
		end
		if (READ_REQ) begin
			armed_d = 1'b1;
		end
	end

	// State registers; the data line only ever pulls low
	always @(posedge CLK) begin
		if (SRST) begin
			clk_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			cs_prev_q <= 1'b1;
			state_q <= ST_IDLE;
			cnt_q <= `SCR_CNT_RST;
			rx_q <= `SCR_FILLER;
			tx_q <= `SCR_IDLE_BYTE;
			out_bit_q <= 1'b1;
			drive_q <= 1'b0;
			hack_q <= 1'b0;
			have_byte_q <= 1'b0;
			hold_q <= 1'b0;
			att_q <= 1'b0;
			armed_q <= 1'b0;
			filler_q <= 1'b0;
			MSG_TAKE <= 1'b0;
			SERIAL_DATA_IO_O <= 1'b0;
			SERIAL_DATA_IO_OE <= 1'b0;
			CONTROL_DATA_OUT <= 1'b1;
			HOST_ATTENTION_N <= 1'b1;
		end else if (CE) begin
			clk_prev_q <= clk_s;
			sda_prev_q <= sda_s;
			cs_prev_q <= cs_n_s;
			state_q <= state_d;
			cnt_q <= cnt_d;
			rx_q <= rx_d;
			tx_q <= tx_d;
			out_bit_q <= out_bit_d;
			drive_q <= drive_d;
			hack_q <= hack_d;
			have_byte_q <= have_byte_d;
			hold_q <= hold_d;
			att_q <= att_d;
			armed_q <= armed_d;
			filler_q <= filler_d;
			MSG_TAKE <= take_d;
			SERIAL_DATA_IO_O <= 1'b0;
			// Ack pulls low; data ones release the line to the pull-up
			SERIAL_DATA_IO_OE <= drive_d & (state_d == ST_AACK | ~out_bit_d);
			CONTROL_DATA_OUT <= out_bit_d;
			HOST_ATTENTION_N <= ~att_d;
		end
	end
endmodule // scr_read_port

// *** scr_read_port_assertions.sv ***
// Checker: link and attention timing at the read port pins.
// Assumes binding onto scr_read_port; single clock domain.
`timescale 1ns/1ps
module scr_read_port_assertions (
	// Clock and reset
	input wire CLK,
	input wire SRST,
	// Link and source
	input wire SERIAL_CONTROL_CLOCK,
	input wire SERIAL_DATA_IO_O,
	input wire SERIAL_DATA_IO_OE,
	input wire HOST_ATTENTION_N,
	input wire MSG_VALID,
	input wire MSG_TAKE,
	input wire UNSOL_EN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	// Cycles the link clock has stood high; a transfer never holds it past four
	reg [3:0] idle_cnt = 4'h0;
	always @(posedge CLK) begin
		if (!SERIAL_CONTROL_CLOCK)
			idle_cnt <= 4'h0;
		else if (idle_cnt != 4'hf)
			idle_cnt <= idle_cnt + 4'h1;
	end
	// Idle link: clock high for more than five cycles, so no hold window is open
	sequence s_idle_msg;
		$rose(MSG_VALID) && UNSOL_EN && (idle_cnt > 4'h5);
	endsequence
	property p_unsol; s_idle_msg |-> ##[1:2] !HOST_ATTENTION_N; endproperty
	property p_edge; $rose(SERIAL_CONTROL_CLOCK) |=> $stable(SERIAL_DATA_IO_OE) [*4]; endproperty
	property p_pull; !SERIAL_DATA_IO_O; endproperty
	property p_hold; $rose(HOST_ATTENTION_N) |-> HOST_ATTENTION_N [*5]; endproperty
	property p_rise; $rose(HOST_ATTENTION_N) |-> $past(SERIAL_CONTROL_CLOCK, 3); endproperty
	property p_fall; $fell(HOST_ATTENTION_N) |-> MSG_VALID || $past(MSG_VALID); endproperty
	property p_take; MSG_TAKE |-> $past(MSG_VALID) ##1 !MSG_TAKE; endproperty
	property p_take_att; MSG_TAKE |-> ##1 !HOST_ATTENTION_N; endproperty
	a_unsol: assert property (p_unsol) else $error("no attention");
	a_edge: assert property (p_edge) else $error("data moved high");
	a_pull: assert property (p_pull) else $error("line driven high");
	a_hold: assert property (p_hold) else $error("attention glitch");
	a_rise: assert property (p_rise) else $error("attention rose early");
	a_fall: assert property (p_fall) else $error("attention without data");
	a_take: assert property (p_take) else $error("bad take");
	a_take_att: assert property (p_take_att) else $error("take with attention high");
endmodule // scr_read_port_assertions
bind scr_read_port scr_read_port_assertions u_chk (.CLK(CLK), .SRST(SRST),
	.SERIAL_CONTROL_CLOCK(SERIAL_CONTROL_CLOCK), .SERIAL_DATA_IO_O(SERIAL_DATA_IO_O),
	.SERIAL_DATA_IO_OE(SERIAL_DATA_IO_OE), .HOST_ATTENTION_N(HOST_ATTENTION_N),
	.MSG_VALID(MSG_VALID), .MSG_TAKE(MSG_TAKE), .UNSOL_EN(UNSOL_EN));

// *** scr_host_model.sv ***
// Host model: paces the link clock, pulls the data wire low, frames four-wire reads.
// Assumes the bench resolves the wire low when any party enables.
`timescale 1ns/1ps
module scr_host_model (
	// Pacing clock
	input wire clk,
	// Link wires and attention
	output reg scl = 1'b1,
	output reg oe = 1'b0,
	output reg cs_n = 1'b1,
	input wire sda,
	input wire att_n,
	// Four-wire mode and its data out
	input wire spi,
	input wire sdo
);
	reg att_pre = 1'b1;
	event rise_ev;
	// Data moves mid low half, never at a clock edge
	task bit_clk(input reg v, output reg s);
		repeat (2) @(negedge clk);
		oe = v;
		repeat (2) @(negedge clk);
		scl = 1'b1;
		-> rise_ev;
		repeat (4) @(negedge clk);
		s = spi ? sdo : sda;
		scl = 1'b0;
	endtask
	// Start: data falls while the clock is high; four-wire drops select, clock idle low
	task start;
		if (spi) begin
			scl = 1'b0;
			cs_n = 1'b0;
		end else begin
			oe = 1'b1;
		end
		repeat (4) @(negedge clk);
		scl = 1'b0;
	endtask
	task addr(input reg [7:0] a, output reg ok);
		int i;
		reg s;
		for (i = 7; i >= 0; i--)
			bit_clk(~a[i], s);
		// Four-wire reads have no acknowledge clock
		s = 1'b0;
		if (!spi)
			bit_clk(1'b0, s);
		ok = ~s;
	endtask
	// Ack while attention low, else NACK; cont forces the ack and models a host that keeps reading
	task rd_byte(output reg [7:0] d, input reg cont);
		int i;
		reg s;
		for (i = 0; i < 8; i++) begin
			bit_clk(1'b0, d[7 - i]);
			// Four-wire N-1 is the D1 clock
			if (spi && i == 6)
				att_pre = att_n;
		end
		if (!spi) begin
			repeat (2) @(negedge clk);
			att_pre = att_n;
			bit_clk(!att_pre || cont, s);
		end
	endtask
	// Stop: data rises while the clock is high; four-wire raises select
	task stop;
		repeat (2) @(negedge clk);
		if (spi) begin
			cs_n = 1'b1;
		end else begin
			oe = 1'b1;
			repeat (2) @(negedge clk);
			scl = 1'b1;
			repeat (4) @(negedge clk);
			oe = 1'b0;
		end
		repeat (4) @(negedge clk);
	endtask
endmodule // scr_host_model

// *** tb_scr_read_port.sv ***
// Bench for the read port: host model reads queued messages over two and four wires.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, (g), (e)); end end
module tb_scr_read_port;
	reg clk = 1'b0;
	reg srst = 1'b1;
	reg valid = 1'b0;
	reg [7:0] data = 8'h00;
	reg unsol = 1'b0;
	reg req = 1'b0;
	reg ce = 1'b1;
	reg spi = 1'b0;
	reg [7:0] q[$];
	reg [7:0] b;
	reg ok;
	int err_count = 0;
	int num_checks = 0;
	wire scl, hoe, doe, att_n, take, cs_n, sdo, so;
	wire sda = ~(hoe | doe);
	// Block clock, 50 ns
	initial forever #25 clk = ~clk;
	scr_read_port dut_u (.CLK(clk), .SRST(srst), .CE(ce), .SPI_MODE(spi),
		.SERIAL_CONTROL_CLOCK(scl), .SERIAL_CHIP_SELECT_N(cs_n), .SERIAL_DATA_IO_I(sda),
		.SERIAL_DATA_IO_O(so), .SERIAL_DATA_IO_OE(doe), .CONTROL_DATA_OUT(sdo),
		.HOST_ATTENTION_N(att_n), .MSG_VALID(valid), .MSG_DATA(data), .MSG_TAKE(take),
		.UNSOL_EN(unsol), .READ_REQ(req));
	scr_host_model u_host (.clk(clk), .scl(scl), .oe(hoe), .cs_n(cs_n), .sda(sda),
		.att_n(att_n), .spi(spi), .sdo(sdo));
	// Source: valid follows the queue so a message stays whole
	always @(negedge clk) begin
		if (take === 1'b1)
			void'(q.pop_front());
		valid = (q.size() != 0);
		data = valid ? q[0] : 8'h00;
	end
	task results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Bounded wait for attention, then start and address
	task open(input reg [7:0] a, input reg exp);
		int i;
		for (i = 0; i < 20 && att_n !== 1'b0 && exp; i++)
			@(negedge clk);
		if (exp) `CHK(att_n, 1'b0)
		u_host.start();
		u_host.addr(a, ok);
		`CHK(ok, exp)
	endtask
	task t_early;
		unsol = 1'b1;
		q.push_back(8'h5a);
		open(8'h01, 1'b1);
		q.push_back(8'h3c);
		u_host.rd_byte(b, 1'b0);
		`CHK(b, 8'h5a)
		`CHK(so, 1'b0)
		`CHK(u_host.att_pre, 1'b0)
		u_host.rd_byte(b, 1'b0);
		`CHK(b, 8'h3c)
		`CHK(u_host.att_pre, 1'b1)
		u_host.stop();
		$display("early done");
	endtask
	task t_refuse;
		open(8'h00, 1'b0);
		u_host.stop();
		open(8'h03, 1'b0);
		u_host.stop();
		$display("refuse done");
	endtask
	// Message lands between rise N-1 and rise N of the last byte
	task t_late(input reg cont);
		q.push_back(8'h42);
		open(8'h01, 1'b1);
		fork
			u_host.rd_byte(b, cont);
			begin
				repeat (spi ? 7 : 8) @(u_host.rise_ev);
				repeat (5) @(negedge clk);
				q.push_back(8'h99);
			end
		join
		`CHK(b, 8'h42)
		`CHK(u_host.att_pre, 1'b1)
		repeat (3) @(negedge clk);
		`CHK(att_n, 1'b0)
		if (cont) begin
			u_host.rd_byte(b, 1'b1);
			`CHK(b, 8'h00)
		end else begin
			u_host.stop();
			open(8'h01, 1'b1);
		end
		u_host.rd_byte(b, 1'b0);
		`CHK(b, 8'h99)
		u_host.stop();
		$display("late done");
	endtask
	task t_sol;
		unsol = 1'b0;
		q.push_back(8'h77);
		repeat (10) @(negedge clk);
		`CHK(att_n, 1'b1)
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		open(8'h01, 1'b1);
		u_host.rd_byte(b, 1'b0);
		`CHK(b, 8'h77)
		u_host.stop();
		q.push_back(8'h11);
		repeat (10) @(negedge clk);
		`CHK(att_n, 1'b1)
		$display("solicited done");
	endtask
	// Enable low freezes attention; a queued message then shows once enabled
	task t_ce;
		ce = 1'b0;
		unsol = 1'b1;
		repeat (10) @(negedge clk);
		`CHK(att_n, 1'b1)
		ce = 1'b1;
		open(8'h01, 1'b1);
		u_host.rd_byte(b, 1'b0);
		`CHK(b, 8'h11)
		`CHK(u_host.att_pre, 1'b1)
		u_host.stop();
		$display("enable done");
	endtask
	// Reset, scenarios, verdict
	initial begin
		repeat (16) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		t_early();
		t_refuse();
		t_late(1'b1);
		t_late(1'b0);
		// Four-wire mode from here on
		spi = 1'b1;
		repeat (4) @(negedge clk);
		t_late(1'b1);
		t_late(1'b0);
		t_sol();
		t_ce();
		results();
	end
	// Watchdog far past the expected run
	initial begin
		#2000000;
		err_count++;
		results();
	end
endmodule // tb_scr_read_port
